/* testbench/mpt_properties.sv */
/* port assertions of the message translator.
   assumes it is bound into every mpt_translator instance. */
`timescale 1ns/1ns
module mpt_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic done,
	input wire logic resend
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// setup phase, and a go write that completes
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence go_s;
		psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0];
	endsequence
	ready_in_access_a: assert property (setup_s |=> pready)
		else $error("no ready in access phase");
	ready_scope_a: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	bad_addr_err_a: assert property (setup_s ##0 (paddr > 8'h28 || paddr[1:0] != 2'h0)
		|=> pslverr) else $error("bad address not refused");
	good_addr_ok_a: assert property (setup_s ##0 (paddr <= 8'h28 && paddr[1:0] == 2'h0)
		|=> !pslverr) else $error("good address refused");
	err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read not zero");
	go_done_a: assert property (go_s |=> done)
		else $error("no done after go");
	done_cause_a: assert property (done |-> $past(pready && pwrite && paddr == 8'h00 && pwdata[0]))
		else $error("done without go");
	done_single_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	addr_byte_a: assert property (setup_s ##0 (!pwrite && paddr == 8'h20)
		|=> prdata[7:0] == 8'h00) else $error("address byte not zero");
	resend_single_a: assert property (resend |=> !resend)
		else $error("resend longer than one cycle");
endmodule : mpt_properties

bind mpt_translator mpt_properties u_mpt_properties (.clk, .reset, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .done, .resend);

/* testbench/mpt_serial_peer.sv */
/* far-side serial device that never answers, counting retransmissions.
   assumes resend is a one-cycle pulse per retransmitted request. */
`timescale 1ns/1ns
module mpt_serial_peer (
	input wire logic clk,
	input wire logic reset,
	input wire logic resend,
	output logic [3:0] resend_cnt
);
	// silent device: every retransmission is seen and counted
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resend_cnt <= 4'h0;
		end else if (resend) begin
			resend_cnt <= resend_cnt + 4'h1;
		end
	end
endmodule : mpt_serial_peer

/* testbench/tb.sv */
/* self-checking bench of the message translator.
   assumes the checker bind and the serial peer model are compiled first. */
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic pready;
	logic pslverr;
	logic done;
	logic resend;
	logic [3:0] resend_cnt;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	mpt_translator u_mpt_translator (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .done, .resend);
	mpt_serial_peer u_mpt_serial_peer (.clk, .reset, .resend, .resend_cnt);
	initial forever #50 clk = ~clk;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		compares++;
		if ((g & m) !== (e & m)) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask : chk
	// one apb transfer; request held until ready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		chk({31'h0, pslverr}, {31'h0, a > 8'h28 || a[1:0] != 2'h0}, 32'h0000_0001);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdat, e, m);
	endtask : rd
	// load one operand register, set the modes, fire go, judge the first result word
	// modes go in first: go latches with the control bits already stored
	task automatic go(input logic [7:0] c, input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] e, input logic [31:0] m);
		bus(1'b1, a, v);
		bus(1'b1, 8'h00, {24'h00_0000, c & 8'hFE});
		bus(1'b1, 8'h00, {24'h00_0000, c | 8'h01});
		rd(8'h18, e, m);
	endtask : go
	task automatic t_reset();
		rd(8'h14, 32'h0000_1003, 32'hFFFF_FFFF);
		rd(8'h24, 32'h0000_03E8, 32'h0000_FFFF);
		rd(8'h2C, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(8'h06, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("test reset finished");
	endtask : t_reset
	task automatic t_serial();
		bus(1'b1, 8'h08, 32'h0000_0003);
		go(8'h00, 8'h04, 32'h0025_0001, 32'h5303_0020, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0025_0005, 32'h0005_0002, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h0020_0003, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0012_000F, 32'h000F_0002, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h001C_0002, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h001E_000F, 32'hBAD5_0122, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0004_0003, 32'h0003_0000, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0004_0004, 32'h0004_0000, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0004_0006, 32'h0006_0002, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0004_0010, 32'h0010_0002, 32'hFFFF_FFFF);
		bus(1'b1, 8'h0C, 32'h0000_FF0F);
		go(8'h00, 8'h04, 32'h0004_0016, 32'h0010_0002, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h00F0_0005, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0004_0064, 32'h0000_0004, 32'h0000_01FF);
		go(8'h00, 8'h04, 32'h0004_0007, 32'hBAD5_0122, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000, 32'h0000_00FF);
		go(8'h10, 8'h04, 32'h0004_0007, 32'hBAD5_0192, 32'hFFFF_FFFF);
		go(8'h04, 8'h04, 32'h0025_0001, 32'hBAD5_0122, 32'hFFFF_FFFF);
		go(8'h04, 8'h04, 32'h0004_0003, 32'h0003_0000, 32'hFFFF_FFFF);
		go(8'h00, 8'h08, 32'h0000_0010, 32'h0003_0000, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h0010_000F, 32'hBAD5_0122, 32'hFFFF_FFFF);
		go(8'h00, 8'h04, 32'h001F_0002, 32'hF005_0020, 32'hFFFF_FFFF);
		$display("test serial to peer finished");
	endtask : t_serial
	task automatic t_peer();
		bus(1'b1, 8'h10, 32'h0005_0020);
		go(8'h02, 8'h14, 32'h01F4_1004, 32'h0000_0003, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_0005, 32'h0000_FFFF);
		go(8'h0A, 8'h10, 32'h0005_0000, 32'h0000_0004, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_01F9, 32'h0000_FFFF);
		go(8'h4A, 8'h10, 32'h0005_0000, 32'h0000_0004, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_0005, 32'h0000_FFFF);
		go(8'h0A, 8'h14, 32'hFFFF_1003, 32'h0000_0003, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_0004, 32'h0000_FFFF);
		bus(1'b1, 8'h10, 32'h0002_0000);
		go(8'h0A, 8'h14, 32'h0001_1001, 32'h0000_0001, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_0021, 32'h0000_FFFF);
		bus(1'b1, 8'h10, 32'h0002_0002);
		bus(1'b1, 8'h08, 32'h0000_0001);
		go(8'h2A, 8'h14, 32'h0000_0F03, 32'h0000_0005, 32'h0000_00FF);
		rd(8'h1C, 32'h0000_0011, 32'h0000_FFFF);
		go(8'h0A, 8'h08, 32'h0000_0001, 32'h0000_000F, 32'h0000_00FF);
		go(8'h1A, 8'h10, 32'h0005_0022, 32'h0000_0011, 32'h0000_00FF);
		rd(8'h20, 32'h0000_0200, 32'h0000_FFFF);
		$display("test peer to serial finished");
	endtask : t_peer
	task automatic t_retry();
		bus(1'b1, 8'h24, 32'h0000_0014);
		bus(1'b1, 8'h00, 32'h0000_0100);
		bus(1'b1, 8'h00, 32'h0000_0200);
		repeat (60) @(posedge clk);
		chk({28'h000_0000, resend_cnt}, 32'h0000_0000, 32'h0000_000F);
		bus(1'b1, 8'h24, 32'h0000_0005);
		bus(1'b1, 8'h00, 32'h0000_0100);
		repeat (40) @(posedge clk);
		chk({28'h000_0000, resend_cnt}, 32'h0000_0002, 32'h0000_000F);
		rd(8'h28, 32'h0000_0008, 32'h0000_0008);
		$display("test retry finished");
	endtask : t_retry
	// reset held for 16 cycles, then the scenarios in turn
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_serial();
		t_peer();
		t_retry();
		report_and_stop();
	end
endmodule : tb

/* verilog/mpt_map.svh */
/*
 * register offsets, field positions, codes and reset values of the
 * message translator.
 * assumes a 32-bit apb bus with word aligned byte addresses.
 */
`ifndef MPT_MAP_SVH
`define MPT_MAP_SVH

// register byte offsets
`define MPT_CTRL_OFS 8'h00
`define MPT_REQ_OFS 8'h04
`define MPT_CNT_OFS 8'h08
`define MPT_MASK_OFS 8'h0C
`define MPT_PEER_OFS 8'h10
`define MPT_HOST_OFS 8'h14
`define MPT_RES0_OFS 8'h18
`define MPT_RES1_OFS 8'h1C
`define MPT_RES2_OFS 8'h20
`define MPT_RTO_OFS 8'h24
`define MPT_RSTAT_OFS 8'h28

// control bit positions
`define MPT_CTRL_GO 0
`define MPT_CTRL_DIR 1
`define MPT_CTRL_NATIVE 2
`define MPT_CTRL_HOST 3
`define MPT_CTRL_REPLY 4
`define MPT_CTRL_SINGLE 5
`define MPT_CTRL_SLAVE 6
`define MPT_CTRL_SENT 8
`define MPT_CTRL_REPOK 9

// peer opcodes
`define MPT_OP_PRI_READ 8'h20
`define MPT_OP_NP_READ 8'h00
`define MPT_OP_RAND_READ 8'h04
`define MPT_OP_PRI_WRITE 8'h1E
`define MPT_OP_NP_WRITE 8'h02
`define MPT_OP_PRINT 8'h22
`define MPT_OP_PRINT_REPLY 8'h92

// serial function codes
`define MPT_FC_RD_COIL 8'h01
`define MPT_FC_RD_INPUT 8'h02
`define MPT_FC_RD_HOLD 8'h03
`define MPT_FC_RD_IREG 8'h04
`define MPT_FC_WR_COIL 8'h05
`define MPT_FC_WR_REG 8'h06
`define MPT_FC_WR_COILS 8'h0F
`define MPT_FC_WR_REGS 8'h10
`define MPT_FC_WR_MASKED 8'h16
`define MPT_FC_ENCAP 8'h11
`define MPT_FC_RAND_READ 8'h64

// status field values
`define MPT_SUB_COIL 8'h03
`define MPT_SUB_INPUT 8'h05
`define MPT_ENCAP_STATUS 16'hBAD5
`define MPT_ENCAP_QUERY 8'h01
`define MPT_ENCAP_REPLY 8'h02
`define MPT_FULL_MASK 16'hFFFF
`define MPT_BITS_PER_REG 5'h10

// reset values and the retry limit
`define MPT_HOST_RST 32'h0000_1003
`define MPT_RTO_RST 16'h03E8
`define MPT_MAX_RETRY 2'h2
`endif

/* verilog/mpt_pkg.sv */
/*
 * types of the message translator.
 * assumes mpt_map.svh is on the include path.
 */
package mpt_pkg;
	// one finished translation, either direction
	typedef struct packed {
		logic [7:0] opcode;
		logic encap;
		logic [15:0] status;
		logic [15:0] addr;
		logic [15:0] mask;
		logic [7:0] param;
	} mpt_result_t;

	// retry engine states
	typedef enum logic [1:0] {
		MPT_R_IDLE,
		MPT_R_WAIT,
		MPT_R_FAIL
	} mpt_retry_t;
endpackage : mpt_pkg

/* verilog/mpt_translator.sv */
/*
 * serial/peer message translator with apb register access.
 * register words, by byte offset:
 *   00 control: go, direction, native target, host mode, reply,
 *      one-coil-as-single, slave side; bit 8 sent, bit 9 reply ok
 *   04 request: function in [7:0], zero-based start in [31:16]
 *   08 count of coils or registers in [15:0]
 *   0c and-mask in [15:0], or-mask kept in [31:16]
 *   10 peer message: opcode in [7:0], remote register in [31:16]
 *   14 host setup: read code, write code, signed offset in [31:16]
 *   18 result: opcode or function, encapsulated flag, status field
 *   1c result: address in [15:0], write mask in [31:16]
 *   20 result: encapsulation parameter in [15:8], address byte zero
 *   24 reply timeout in clock cycles
 *   28 retry state: retries, waiting, failed
 * go, sent and reply ok are strobes and read back as zero.
 * a result is only as good as the operand words written before go;
 * control bits written together with go take effect for the next go.
 * assumes a single 10 MHz clock, asynchronous active high reset and
 * a message engine outside that moves bytes according to the results.
 */
// The APB slave port and the placing of the registers were left to the implementer.
// Notes on behaviour
// - read coils becomes priority read, status MN03
// - read inputs becomes priority read, status MN05
// - register reads become non-priority read, 03/04
// - single coil write uses one-bit mask, 05
// - single register write uses transaction 06
// - multiple coils only inside one register
// - one-coil multiple write may return as single
// - multiple register write uses transaction 10
// - masked write uses transaction 10, derived mask
// - random read becomes random access read
// - untranslatable query wrapped in print BAD5
// - untranslatable reply wrapped in print reply
// - encapsulated address byte sent zero, ignored
// - native target translates only 3,16,22,100
// - host mode uses configured codes and offset
// - offset is a signed sixteen bit value
// - offset only for outgoing host translations
// - register address equals remote plus offset
// - gate and slave side use zero offset
// - coil start ((remote+offset-1)*16)+1
// - peer commands ride function 17, 01/02
// - resend after timeout, at most two retries
`timescale 1ns/1ns
`include "mpt_map.svh"

module mpt_translator import mpt_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic done,
	output logic resend
);
	// software visible registers
	logic [31:0] ctrl_r;
	logic [31:0] req_r;
	logic [31:0] cnt_r;
	logic [31:0] mask_r;
	logic [31:0] peer_r;
	logic [31:0] host_r;
	logic [15:0] rto_r;
	// latched result and its next value
	mpt_result_t res_r;
	mpt_result_t res_nxt;
	// retry engine
	mpt_retry_t rstate_r;
	logic [1:0] retries_r;
	logic [15:0] rtimer_r;
	// strobes decoded from the access phase; mapped is the address check used in the setup phase
	logic go;
	logic sent;
	logic rep_ok;
	logic wr_acc;
	logic rd_acc;
	logic mapped;

	// decoded fields
	logic dir;
	logic native;
	logic host_mode;
	logic is_reply;
	logic single_ok;
	logic slave_side;
	logic [7:0] fc;
	logic [15:0] start;
	logic [15:0] count;
	logic [7:0] peer_op;
	logic [15:0] remote;
	logic signed [15:0] bias;
	logic [15:0] reg_addr;
	logic [15:0] coil_addr;
	logic [4:0] span;
	logic [15:0] coil_mask;
	logic translatable;

	assign dir = ctrl_r[`MPT_CTRL_DIR];
	assign native = ctrl_r[`MPT_CTRL_NATIVE];
	assign host_mode = ctrl_r[`MPT_CTRL_HOST];
	assign is_reply = ctrl_r[`MPT_CTRL_REPLY];
	assign single_ok = ctrl_r[`MPT_CTRL_SINGLE];
	assign slave_side = ctrl_r[`MPT_CTRL_SLAVE];
	assign fc = req_r[7:0];
	assign start = req_r[31:16];
	assign count = cnt_r[15:0];
	assign peer_op = peer_r[7:0];
	assign remote = peer_r[31:16];

	// apb access phase; zero wait states, one-cycle access
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `MPT_RSTAT_OFS);
	assign go = wr_acc && (paddr == `MPT_CTRL_OFS) && pwdata[`MPT_CTRL_GO];
	assign sent = wr_acc && (paddr == `MPT_CTRL_OFS) && pwdata[`MPT_CTRL_SENT];
	assign rep_ok = wr_acc && (paddr == `MPT_CTRL_OFS) && pwdata[`MPT_CTRL_REPOK];

	// offset is zero in gate mode and on the slave side
	// the offset is signed: a value above 7fff moves the serial address
	// below the remote one, wrapping modulo 65536 like the serial side
	assign bias = (host_mode && !slave_side) ? host_r[31:16] : 16'sh0000;
	// register functions: remote plus offset
	assign reg_addr = remote + bias;
	// coil functions: sixteen coils per remote register, from bit 1
	assign coil_addr = ((remote + bias - 16'h0001) << 4) + 16'h0001;

	// coil span check for multiple coil writes; a run that would spill
	// into the next register cannot be expressed by one masked write,
	// so it is encapsulated instead of being split into two messages.
	// count is below sixteen where span is used, so five bits suffice
	assign span = {1'b0, start[3:0]} + count[4:0];
	assign coil_mask = 16'(((17'h0_0001 << count[4:0]) - 17'h0_0001) << start[3:0]);

	// which serial functions have a peer equivalent in this target mode
	// the four functions of the native list pass in every target mode;
	// the rest only when the target is not a native serial device
	always_comb begin
		unique case (fc)
			`MPT_FC_RD_HOLD, `MPT_FC_WR_REGS,
			`MPT_FC_WR_MASKED, `MPT_FC_RAND_READ: translatable = 1'b1;
			`MPT_FC_RD_COIL, `MPT_FC_RD_INPUT, `MPT_FC_RD_IREG,
			`MPT_FC_WR_COIL, `MPT_FC_WR_REG: translatable = !native;
			`MPT_FC_WR_COILS: begin
				// whole run must sit inside one register
				translatable = !native && (count != 16'h0000) && (count < 16'h0010)
					&& (span <= `MPT_BITS_PER_REG);
			end
			default: translatable = 1'b0;
		endcase
	end

	// translation of one message in either direction
	always_comb begin
		res_nxt = '0;
		res_nxt.mask = `MPT_FULL_MASK;
		if (!dir) begin
			// serial request toward the peer network; zero offset here
			// peer registers are one based and the request start is zero
			// based, hence the plus one; no offset for a serial master
			res_nxt.addr = start + 16'h0001;
			if (!translatable) begin
				res_nxt.opcode = is_reply ? `MPT_OP_PRINT_REPLY : `MPT_OP_PRINT;
				res_nxt.encap = 1'b1;
				res_nxt.status = `MPT_ENCAP_STATUS;
				// the frame keeps the start unchanged so that the far
				// translator can rebuild the original request
				res_nxt.addr = start;
				res_nxt.param = 8'h00;
			end else begin
				unique case (fc)
					`MPT_FC_RD_COIL: begin
						res_nxt.opcode = `MPT_OP_PRI_READ;
						res_nxt.status = {start[3:0], count[3:0], `MPT_SUB_COIL};
						res_nxt.addr = {4'h0, start[15:4]} + 16'h0001;
					end
					`MPT_FC_RD_INPUT: begin
						res_nxt.opcode = `MPT_OP_PRI_READ;
						res_nxt.status = {start[3:0], count[3:0], `MPT_SUB_INPUT};
						res_nxt.addr = {4'h0, start[15:4]} + 16'h0001;
					end
					`MPT_FC_RD_HOLD, `MPT_FC_RD_IREG: begin
						res_nxt.opcode = `MPT_OP_NP_READ;
						res_nxt.status = {8'h00, fc};
					end
					`MPT_FC_WR_COIL: begin
						res_nxt.opcode = `MPT_OP_NP_WRITE;
						res_nxt.status = {8'h00, fc};
						res_nxt.addr = {4'h0, start[15:4]} + 16'h0001;
						res_nxt.mask = 16'h0001 << start[3:0];
					end
					`MPT_FC_WR_REG, `MPT_FC_WR_REGS: begin
						res_nxt.opcode = `MPT_OP_NP_WRITE;
						res_nxt.status = {8'h00, fc};
					end
					`MPT_FC_WR_COILS: begin
						res_nxt.opcode = `MPT_OP_NP_WRITE;
						res_nxt.status = {8'h00, fc};
						res_nxt.addr = {4'h0, start[15:4]} + 16'h0001;
						res_nxt.mask = coil_mask;
					end
					`MPT_FC_WR_MASKED: begin
						// bits cleared in the and-mask are the ones written
						res_nxt.opcode = `MPT_OP_NP_WRITE;
						res_nxt.status = {8'h00, `MPT_FC_WR_REGS};
						res_nxt.mask = ~mask_r[15:0];
					end
					`MPT_FC_RAND_READ: begin
						res_nxt.opcode = `MPT_OP_RAND_READ;
					end
					default: res_nxt.opcode = `MPT_OP_PRINT;
				endcase
			end
		end else begin
			// peer message toward a serial slave
			// the function comes from the host setup in host mode and from
			// the fixed table in gate mode; unknown opcodes ride function 17
			unique case (peer_op)
				`MPT_OP_PRI_READ, `MPT_OP_NP_READ: begin
					res_nxt.opcode = host_mode ? host_r[7:0] : `MPT_FC_RD_HOLD;
				end
				`MPT_OP_PRI_WRITE, `MPT_OP_NP_WRITE: begin
					res_nxt.opcode = host_mode ? host_r[15:8] : `MPT_FC_WR_REGS;
					// a one-coil run may go out as a single coil write
					if (res_nxt.opcode == `MPT_FC_WR_COILS && count == 16'h0001
						&& single_ok) begin
						res_nxt.opcode = `MPT_FC_WR_COIL;
					end
				end
				default: begin
					res_nxt.opcode = `MPT_FC_ENCAP;
					res_nxt.encap = 1'b1;
					res_nxt.param = is_reply ? `MPT_ENCAP_REPLY : `MPT_ENCAP_QUERY;
				end
			endcase
			// coil functions address sixteen coils per remote register
			if (res_nxt.opcode == `MPT_FC_RD_COIL || res_nxt.opcode == `MPT_FC_WR_COIL
				|| res_nxt.opcode == `MPT_FC_WR_COILS) begin
				res_nxt.addr = coil_addr;
			end else begin
				res_nxt.addr = reg_addr;
			end
		end
	end

	// control and request registers; go, sent and ack bits self clear
	// writes to result and status words are dropped, as are writes to
	// unmapped offsets; the bus still answers them in one access cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= 32'h0000_0000;
			req_r <= 32'h0000_0000;
			cnt_r <= 32'h0000_0000;
			mask_r <= 32'h0000_0000;
			peer_r <= 32'h0000_0000;
			host_r <= `MPT_HOST_RST;
			rto_r <= `MPT_RTO_RST;
		end else if (wr_acc) begin
			unique case (paddr)
				`MPT_CTRL_OFS: ctrl_r <= {25'h000_0000, pwdata[6:1], 1'b0};
				`MPT_REQ_OFS: req_r <= pwdata;
				`MPT_CNT_OFS: cnt_r <= pwdata;
				`MPT_MASK_OFS: mask_r <= pwdata;
				`MPT_PEER_OFS: peer_r <= pwdata;
				`MPT_HOST_OFS: host_r <= pwdata;
				`MPT_RTO_OFS: rto_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// result latch; the result of the last go stays until the next
	// the result uses the control bits stored before this write, so
	// software sets direction and modes first and then strobes go
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			res_r <= '0;
			done <= 1'b0;
		end else begin
			done <= go;
			if (go) begin
				res_r <= res_nxt;
			end
		end
	end

	// retry engine: a lost reply costs one timeout, then a resend
	// the timer is loaded with the timeout and counts down to one; the
	// cycle at one either resends or gives up, so each resend follows
	// its send by the timeout's worth of cycles. a reply ok strobe wins
	// over an expiring timer in the same cycle. a timeout of zero or one
	// resends in back to back cycles, so software keeps it above one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rstate_r <= MPT_R_IDLE;
			retries_r <= 2'h0;
			rtimer_r <= 16'h0000;
			resend <= 1'b0;
		end else begin
			resend <= 1'b0;
			unique case (rstate_r)
				MPT_R_IDLE, MPT_R_FAIL: begin
					if (sent) begin
						rstate_r <= MPT_R_WAIT;
						retries_r <= 2'h0;
						rtimer_r <= rto_r;
					end
				end
				MPT_R_WAIT: begin
					if (rep_ok) begin
						rstate_r <= MPT_R_IDLE;
					end else if (rtimer_r > 16'h0001) begin
						rtimer_r <= rtimer_r - 16'h0001;
					end else if (retries_r == `MPT_MAX_RETRY) begin
						rstate_r <= MPT_R_FAIL;
					end else begin
						retries_r <= retries_r + 2'h1;
						rtimer_r <= rto_r;
						resend <= 1'b1;
					end
				end
				default: rstate_r <= MPT_R_IDLE;
			endcase
		end
	end

	// apb read data and answer; unmapped addresses give slverr
	// read data is chosen in the setup cycle so that it stands in the
	// access cycle; this costs a 32-bit register but keeps the bus free
	// of wait states
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`MPT_CTRL_OFS: prdata <= ctrl_r;
					`MPT_REQ_OFS: prdata <= req_r;
					`MPT_CNT_OFS: prdata <= cnt_r;
					`MPT_MASK_OFS: prdata <= mask_r;
					`MPT_PEER_OFS: prdata <= peer_r;
					`MPT_HOST_OFS: prdata <= host_r;
					`MPT_RES0_OFS: prdata <= {res_r.status, 7'h00, res_r.encap, res_r.opcode};
					`MPT_RES1_OFS: prdata <= {res_r.mask, res_r.addr};
					`MPT_RES2_OFS: prdata <= {16'h0000, res_r.param, 8'h00};
					`MPT_RTO_OFS: prdata <= {16'h0000, rto_r};
					`MPT_RSTAT_OFS: prdata <= {28'h000_0000, rstate_r == MPT_R_FAIL,
						rstate_r == MPT_R_WAIT, retries_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : mpt_translator
